// [rtl/rrnc_pkg.sv]
// Package: constants for the rotate-right-without-carry execution block
package rrnc_pkg;
  localparam int DATA_W = 8;
  localparam int OPC_W = 16;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  // Opcode layout
  localparam logic [5:0] OPC_ROT_RIGHT = 6'h10;
  localparam int OPC_HI_LSB = 10;
  localparam int OPC_DEST_BIT = 9;
  localparam int OPC_ACC_BIT = 8;
  localparam int OPC_F_MSB = 7;
  localparam int DATA_MSB = 7;
  // Access bank split and indexed window limit
  localparam logic [7:0] ACC_LOW_LIMIT = 8'h5F;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [BANK_W-1:0] ACC_HIGH_BANK = 4'hF;
  localparam logic [BANK_W-1:0] ACC_LOW_BANK = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
endpackage

// [rtl/rrnc_exec.sv]
// Rotate-right-without-carry execution unit for an 8-bit core
//////////////////////////////////////////////////////////////////////
// How it works
// - rotate register right one bit; bit 0 wraps into bit 7; no carry.
// - destination bit 0 writes result to the working accumulator only.
// - destination bit 1 writes result back into the source register.
// - bank-access bit 0 addresses the access bank, ignoring the bank pointer.
// - bank-access bit 1 uses the bank pointer to form the address.
// - extended set, access bit 0, field <= 95: indexed literal offset address.
//////////////////////////////////////////////////////////////////////
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module rrnc_exec
  import rrnc_pkg::*;
(
  input wire logic core_clk_in, // 200 MHz core clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic issue_in, // One-cycle instruction issue strobe
  input wire logic [OPC_W-1:0] opcode_in, // Instruction word
  input wire logic [BANK_W-1:0] bank_select_pointer_in, // Current bank number
  input wire logic ext_set_en_in, // Extended instruction set enabled
  input wire logic [ADDR_W-1:0] index_base_in, // Index register for literal offset
  input wire logic [DATA_W-1:0] rd_data_in, // Operand read at rd_addr_out, same cycle
  input wire logic [DATA_W-1:0] wreg_in, // Current working accumulator
  output logic [ADDR_W-1:0] rd_addr_out, // Registered operand address
  output logic [DATA_W-1:0] wreg_out, // Working accumulator
  output logic [ADDR_W-1:0] wr_addr_out, // Register file write address
  output logic [DATA_W-1:0] wr_data_out, // Register file write data
  output logic wr_en_out, // Register file write pulse
  output logic wreg_en_out, // Accumulator updated pulse
  output logic flag_n_out, // Negative flag
  output logic flag_z_out, // Zero flag
  output logic flag_we_out, // Flags updated pulse
  output logic done_out // Instruction completed pulse
);
  //////////////////////////////////////////////////////////////////////
  // Decode stage: latch address and destination
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic dest_r, dest_nxt;
  logic exec_r, exec_nxt;
  logic [7:0] f_fld;
  logic is_op;

  always_comb begin
    f_fld = opcode_in[OPC_F_MSB:0];
    is_op = issue_in && (opcode_in[OPC_W-1:OPC_HI_LSB] == OPC_ROT_RIGHT);
    exec_nxt = is_op;
    dest_nxt = is_op ? opcode_in[OPC_DEST_BIT] : dest_r;
    addr_nxt = addr_r;
    if (is_op) begin
      if (opcode_in[OPC_ACC_BIT]) begin
        addr_nxt = {bank_select_pointer_in, f_fld};
      end else if (ext_set_en_in && (f_fld <= ACC_LOW_LIMIT)) begin
        // Index plus literal; wraps in the 12-bit space like the core does
        addr_nxt = index_base_in + {{(ADDR_W-8){1'b0}}, f_fld};
      end else if (f_fld < ACC_SPLIT) begin
        addr_nxt = {ACC_LOW_BANK, f_fld};
      end else begin
        addr_nxt = {ACC_HIGH_BANK, f_fld};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_r <= ADDR_RST;
      dest_r <= 1'b0;
      exec_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      dest_r <= dest_nxt;
      exec_r <= exec_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Execute stage: rotate and write back
  logic [DATA_W-1:0] rot;
  logic [DATA_W-1:0] wreg_r, wreg_nxt, wdat_r, wdat_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic wen_r, wen_nxt, wregen_r, wregen_nxt, fwe_r, fwe_nxt, done_r, done_nxt;
  logic fn_r, fn_nxt, fz_r, fz_nxt;

  always_comb begin
    rot = {rd_data_in[0], rd_data_in[DATA_MSB:1]};
    wreg_nxt = wreg_in;
    wdat_nxt = wdat_r;
    waddr_nxt = waddr_r;
    wen_nxt = 1'b0;
    wregen_nxt = 1'b0;
    fwe_nxt = exec_r;
    done_nxt = exec_r;
    fn_nxt = fn_r;
    fz_nxt = fz_r;
    if (exec_r) begin
      fn_nxt = rot[DATA_MSB];
      fz_nxt = (rot == DATA_RST);
      if (dest_r) begin
        wdat_nxt = rot;
        waddr_nxt = addr_r;
        wen_nxt = 1'b1;
      end else begin
        wreg_nxt = rot;
        wregen_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wreg_r <= DATA_RST;
      wdat_r <= DATA_RST;
      waddr_r <= ADDR_RST;
      wen_r <= 1'b0;
      wregen_r <= 1'b0;
      fwe_r <= 1'b0;
      done_r <= 1'b0;
      fn_r <= 1'b0;
      fz_r <= 1'b0;
    end else begin
      wreg_r <= wreg_nxt;
      wdat_r <= wdat_nxt;
      waddr_r <= waddr_nxt;
      wen_r <= wen_nxt;
      wregen_r <= wregen_nxt;
      fwe_r <= fwe_nxt;
      done_r <= done_nxt;
      fn_r <= fn_nxt;
      fz_r <= fz_nxt;
    end
  end

  assign rd_addr_out = addr_r;
  assign wreg_out = wreg_r;
  assign wr_addr_out = waddr_r;
  assign wr_data_out = wdat_r;
  assign wr_en_out = wen_r;
  assign wreg_en_out = wregen_r;
  assign flag_n_out = fn_r;
  assign flag_z_out = fz_r;
  assign flag_we_out = fwe_r;
  assign done_out = done_r;
endmodule
`default_nettype wire

// [dv/rrnc_exec_checker.sv]
// Rotate unit checker
`timescale 1ns/100ps
`default_nettype none
module rrnc_exec_checker import rrnc_pkg::*; (
  input wire logic core_clk_in, rst_n_in, issue_in, ext_set_en_in, // Clock, reset, controls
  input wire logic wr_en_out, wreg_en_out, flag_z_out, done_out, // Pulses, zero flag
  input wire logic flag_n_out, // Negative flag
  input wire logic [OPC_W-1:0] opcode_in, // Opcode
  input wire logic [BANK_W-1:0] bank_select_pointer_in, // Bank
  input wire logic [ADDR_W-1:0] index_base_in, rd_addr_out, // Base, operand address
  input wire logic [DATA_W-1:0] rd_data_in, wr_data_out // Operand, result
);
  wire logic [7:0] f = opcode_in[7:0];
  wire logic go = issue_in && opcode_in[15:10] == OPC_ROT_RIGHT;
  wire logic acc = go && !opcode_in[8];
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rot_wrap: assert property (wr_en_out |-> wr_data_out ==
    (($past(rd_data_in) >> 1) | ($past(rd_data_in) << 7))) else $error("rotate");
  a_to_acc: assert property (go && !opcode_in[9] |-> ##2 wreg_en_out) else $error("target");
  a_to_reg: assert property (go && opcode_in[9] |-> ##2 wr_en_out) else $error("target");
  a_bank_acc: assert property (acc && !ext_set_en_in && f < ACC_SPLIT |=>
    rd_addr_out == {ACC_LOW_BANK, $past(f)}) else $error("address");
  a_bank_ptr: assert property (go && opcode_in[8] |=>
    rd_addr_out == {$past(bank_select_pointer_in), $past(f)}) else $error("address");
  a_idx_addr: assert property (acc && ext_set_en_in && f <= ACC_LOW_LIMIT |=>
    rd_addr_out == $past(index_base_in) + 12'($past(f))) else $error("address");
  a_zero_flag: assert property (done_out |-> flag_z_out == ~|$past(rd_data_in))
    else $error("zero flag");
  a_neg_flag: assert property (done_out |-> flag_n_out == $past(rd_data_in[0]))
    else $error("negative flag");
  a_bank_high: assert property (acc && f >= ACC_SPLIT |=>
    rd_addr_out == {ACC_HIGH_BANK, $past(f)}) else $error("address");
  a_one_target: assert property (!(wr_en_out && wreg_en_out)) else $error("two targets");
  cover property (go && opcode_in[8]);
  cover property (go && opcode_in[9]);
  cover property (go && !opcode_in[9]);
  cover property (acc && ext_set_en_in);
endmodule
bind rrnc_exec rrnc_exec_checker u_chk (.*);
`default_nettype wire

// [dv/rrnc_exec_tb.sv]
// Rotate unit bench
`timescale 1ns/100ps
`default_nettype none
module rrnc_exec_tb;
  import rrnc_pkg::*;
  logic core_clk_in = 0, rst_n_in = 0, issue_in = 0, ext_set_en_in = 0, wr_en_out;
  logic wreg_en_out, flag_n_out, flag_z_out, flag_we_out, done_out;
  logic [15:0] opcode_in = '0;
  logic [3:0] bank_select_pointer_in = '0;
  logic [11:0] index_base_in = '0, rd_addr_out, wr_addr_out;
  logic [7:0] rd_data_in = '0, wreg_in = '0, wreg_out, wr_data_out;
  logic [31:0] lf = 32'h8;
  logic [20:0] e, q[$];
  logic [11:0] ea;
  int n_mismatch = 0, total_checks = 0;
  rrnc_exec dut (.*);
  always #2.5 core_clk_in = ~core_clk_in;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [11:0] s, x);
    total_checks++;
    if (s !== x) n_mismatch++;
    if (s !== x) $display("unexpected %0t got %h", $time, s);
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Random issue in three of four cycles (lf[9] | lf[3]); a quarter of opcodes are foreign and must be ignored
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (600) begin
      @(posedge core_clk_in);
      lf = lfsr_next(lf);
      if (issue_in && opcode_in[15:10] == OPC_ROT_RIGHT) begin
        // Expected operand address from the addressing rules
        if (opcode_in[8]) ea = {bank_select_pointer_in, opcode_in[7:0]};
        else if (ext_set_en_in && opcode_in[7:0] <= 8'h5F)
          ea = index_base_in + 12'(opcode_in[7:0]);
        else ea = {(opcode_in[7:0] >= 8'h60) ? 4'hF : 4'h0, opcode_in[7:0]};
        q.push_back({ea, opcode_in[9], lf[0], lf[7:1]});
      end
      rd_data_in <= lf[7:0];
      wreg_in <= lf[27:20];
      issue_in <= lf[9] | lf[3];
      opcode_in <= {5'h08, &lf[31:30], lf[19:10]};
      {ext_set_en_in, bank_select_pointer_in, index_base_in} <= lf[28:12];
    end
    issue_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    // Every accepted issue must have completed by now
    if (q.size() != 0) chk(12'(q.size()), 12'h000);
    final_report();
  end
  always @(negedge core_clk_in) if (done_out === 1'b1) begin
    if (q.size() == 0) chk(12'hFFF, 12'h000);
    else begin
      e = q.pop_front();
      chk(12'(e[8] ? wr_data_out : wreg_out), 12'(e[7:0]));
      chk(12'({wr_en_out, wreg_en_out, flag_we_out, flag_n_out, flag_z_out}),
        12'({e[8], !e[8], 1'b1, e[7], ~|e[7:0]}));
      if (e[8]) chk(wr_addr_out, e[20:9]);
    end
  end
endmodule
`default_nettype wire
